// [fps_pkg.sv]
// Purpose: constants for the flash program/erase sequencer (host side)
// Assumes: 125 MHz clock, byte-wide flash with 17 address bits
// Notes: cycle counts derived from times in their own units, except SUPPLY_SETTLE_CYC, a fixed 64
package fps_pkg;
  localparam int CLK_MHZ = 125;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  // command codes and data values
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_VFY = 8'hA0;
  localparam logic [7:0] CMD_PROG = 8'h40;
  localparam logic [7:0] CMD_PROG_VFY = 8'hC0;
  localparam logic [7:0] DATA_ERASED = 8'hFF;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  // pulse counts
  localparam logic [4:0] PROG_MAX_PULSES = 5'h19;
  localparam logic [9:0] ERASE_MAX_PULSES = 10'h3E8;
  // times
  localparam int PROG_PULSE_US = 10;
  localparam int ERASE_PULSE_TIME_MS = 10;
  localparam int VERIFY_READ_DELAY_NS = 6000;
  localparam int WE_LOW_NS = 48;
  localparam int PROG_PULSE_CYC = PROG_PULSE_US * CLK_MHZ;
  localparam int ERASE_PULSE_CYC = ERASE_PULSE_TIME_MS * 1000 * CLK_MHZ;
  localparam int VERIFY_DELAY_CYC = (VERIFY_READ_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int WE_LOW_CYC = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int SUPPLY_SETTLE_CYC = 64;
  localparam int TMR_W = 24;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 17'h1FFFF;
endpackage : fps_pkg

// [fps_sequencer.sv]
// Purpose: host controller running byte program and chip erase flows
// Assumes: flash bus inputs synchronous to clk; supply switch external
// Notes: one write or read bus cycle at a time; timers use one counter
module fps_sequencer
  import fps_pkg::*;
#(
  parameter int ERASE_CYC = ERASE_PULSE_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start_prog,
  input wire logic start_erase,
  input wire logic [ADDR_W-1:0] prog_addr,
  input wire logic [DATA_W-1:0] prog_data,
  input wire logic supply_ready,
  input wire logic [DATA_W-1:0] fl_dq_in,
  output logic [ADDR_W-1:0] fl_addr,
  output logic [DATA_W-1:0] fl_dq_out,
  output logic fl_dq_oe,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  output logic supply_high_level,
  output logic busy,
  output logic done,
  output logic prog_fail,
  output logic erase_fail
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00000,
    S_SUPPLY = 5'b00001,
    S_BLANK_RD = 5'b00010,
    S_PP_SETUP = 5'b00011,
    S_PP_DATA = 5'b00100,
    S_PP_PULSE = 5'b00101,
    S_PP_VFY = 5'b00110,
    S_PP_DLY = 5'b00111,
    S_PP_RD = 5'b01000,
    S_ER_SETUP = 5'b01001,
    S_ER_GO = 5'b01010,
    S_ER_PULSE = 5'b01011,
    S_EV_CMD = 5'b01100,
    S_EV_DLY = 5'b01101,
    S_EV_RD = 5'b01110,
    S_FIN = 5'b01111,
    S_SETTLE = 5'b10000
  } fps_state_e;

  typedef enum logic [1:0] {
    B_IDLE = 2'b00,
    B_WR = 2'b01,
    B_RD = 2'b10
  } fps_bus_e;

  fps_state_e state;
  fps_state_e next_state;
  fps_bus_e bstate;
  logic [ADDR_W-1:0] addr; // address pointer
  logic [DATA_W-1:0] wdata;
  logic [4:0] ppulse;
  logic [9:0] epulse;
  logic [TMR_W-1:0] tmr;
  logic [3:0] bcnt;
  logic bus_go;
  logic bus_wr;
  logic bus_done;
  logic [DATA_W-1:0] rd_data;
  logic erasing; // erase flow vs plain program
  logic fail_p;
  logic fail_e;

  // bus cycle length helper
  function automatic logic [3:0] cyc4(input int n);
    cyc4 = 4'(n);
  endfunction : cyc4

  // one write or read bus cycle; we low only together with ce
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bstate <= B_IDLE;
      bcnt <= 4'h0;
      fl_ce_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_dq_oe <= 1'b0;
      fl_dq_out <= 8'h00;
      fl_addr <= '0;
      rd_data <= 8'h00;
      bus_done <= 1'b0;
    end else begin
      bus_done <= 1'b0;
      case (bstate)
        B_IDLE: begin
          if (bus_go) begin
            // address driven on the same clock edge that we falls
            fl_addr <= addr;
            fl_dq_out <= wdata;
            fl_ce_n <= 1'b0;
            fl_we_n <= !bus_wr;
            fl_oe_n <= bus_wr;
            fl_dq_oe <= bus_wr;
            bcnt <= 4'h0;
            bstate <= bus_wr ? B_WR : B_RD;
          end
        end
        B_WR, B_RD: begin
          bcnt <= bcnt + 4'h1;
          if (bcnt == cyc4(WE_LOW_CYC)) begin
            // we and ce high inhibit writes
            fl_we_n <= 1'b1;
            fl_ce_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_dq_oe <= 1'b0;
            rd_data <= fl_dq_in;
            bus_done <= 1'b1;
            bstate <= B_IDLE;
          end
        end
        default: bstate <= B_IDLE;
      endcase
    end
  end

  // bus requests per state
  always_comb begin
    bus_go = 1'b0;
    bus_wr = 1'b1;
    wdata = CMD_READ;
    case (state)
      S_BLANK_RD, S_PP_RD, S_EV_RD: begin
        bus_go = (bstate == B_IDLE) && !bus_done;
        bus_wr = 1'b0;
      end
      S_PP_SETUP: begin
        bus_go = (bstate == B_IDLE) && !bus_done;
        wdata = CMD_PROG;
      end
      S_PP_DATA: begin
        bus_go = (bstate == B_IDLE) && !bus_done;
        wdata = erasing ? DATA_ZERO : prog_data;
      end
      S_PP_VFY: begin
        bus_go = (bstate == B_IDLE) && !bus_done;
        wdata = CMD_PROG_VFY;
      end
      S_ER_SETUP, S_ER_GO: begin
        bus_go = (bstate == B_IDLE) && !bus_done;
        wdata = CMD_ERASE;
      end
      S_EV_CMD: begin
        bus_go = (bstate == B_IDLE) && !bus_done;
        wdata = CMD_ERASE_VFY;
      end
      S_FIN: begin
        bus_go = (bstate == B_IDLE) && !bus_done;
        wdata = CMD_READ;
      end
      default: bus_go = 1'b0;
    endcase
  end

  // next state of the flow
  always_comb begin
    next_state = state;
    fail_p = 1'b0;
    fail_e = 1'b0;
    case (state)
      S_IDLE: if (start_prog || start_erase) next_state = S_SUPPLY;
      S_SUPPLY: if (supply_ready) next_state = erasing ? S_BLANK_RD : S_PP_SETUP;
      S_BLANK_RD: if (bus_done) begin
        if (rd_data != DATA_ERASED) next_state = S_PP_SETUP;
        else if (addr == ADDR_LAST) next_state = S_FIN;
      end
      S_PP_SETUP: if (bus_done) next_state = S_PP_DATA;
      S_PP_DATA: if (bus_done) next_state = S_PP_PULSE;
      S_PP_PULSE: if (tmr == TMR_W'(PROG_PULSE_CYC)) next_state = S_PP_VFY;
      S_PP_VFY: if (bus_done) next_state = S_PP_DLY;
      S_PP_DLY: if (tmr == TMR_W'(VERIFY_DELAY_CYC)) next_state = S_PP_RD;
      S_PP_RD: if (bus_done) begin
        if (rd_data == wdata_target()) begin
          if (!erasing) next_state = S_FIN;
          else if (addr == ADDR_LAST) next_state = S_ER_SETUP;
          else next_state = S_PP_SETUP;
        end else if (ppulse == PROG_MAX_PULSES) begin
          fail_p = 1'b1;
          next_state = S_FIN;
        end else next_state = S_PP_SETUP;
      end
      S_ER_SETUP: if (bus_done) next_state = S_ER_GO;
      S_ER_GO: if (bus_done) next_state = S_ER_PULSE;
      S_ER_PULSE: if (tmr == TMR_W'(ERASE_CYC)) next_state = S_EV_CMD;
      S_EV_CMD: if (bus_done) next_state = S_EV_DLY;
      S_EV_DLY: if (tmr == TMR_W'(VERIFY_DELAY_CYC)) next_state = S_EV_RD;
      S_EV_RD: if (bus_done) begin
        if (rd_data == DATA_ERASED) begin
          next_state = (addr == ADDR_LAST) ? S_FIN : S_EV_CMD;
        end else if (epulse == ERASE_MAX_PULSES) begin
          fail_e = 1'b1;
          next_state = S_FIN;
        end else next_state = S_ER_SETUP;
      end
      S_FIN: if (bus_done) next_state = S_SETTLE;
      S_SETTLE: if (tmr == TMR_W'(SUPPLY_SETTLE_CYC)) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // expected verify data
  function automatic logic [7:0] wdata_target();
    wdata_target = erasing ? DATA_ZERO : prog_data;
  endfunction : wdata_target

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) state <= S_IDLE;
    else state <= next_state;
  end

  // phase timer, cleared on each state change
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) tmr <= '0;
    else if (next_state != state) tmr <= '0;
    else tmr <= tmr + TMR_W'(1);
  end

  // address pointer, pulse counters, flow flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr <= '0;
      ppulse <= 5'h00;
      epulse <= 10'h000;
      erasing <= 1'b0;
    end else begin
      if (state == S_IDLE && (start_prog || start_erase)) begin
        erasing <= start_erase;
        addr <= start_erase ? '0 : prog_addr;
        ppulse <= 5'h00;
        epulse <= 10'h000;
      end
      if (state == S_BLANK_RD && bus_done) begin
        // non-blank restarts at zero to preprogram
        if (rd_data != DATA_ERASED) addr <= '0;
        else if (addr != ADDR_LAST) addr <= addr + ADDR_W'(1);
      end
      if (state == S_PP_DATA && bus_done) ppulse <= ppulse + 5'h01;
      if (state == S_PP_RD && bus_done && rd_data == wdata_target()) begin
        ppulse <= 5'h00;
        if (erasing && addr != ADDR_LAST) addr <= addr + ADDR_W'(1);
        if (erasing && addr == ADDR_LAST) addr <= '0;
      end
      if (state == S_EV_RD && bus_done) begin
        if (rd_data != DATA_ERASED) epulse <= epulse + 10'h001;
        // keep last good address, step up
        else if (addr != ADDR_LAST) addr <= addr + ADDR_W'(1);
      end
    end
  end

  // status and supply outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      supply_high_level <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      prog_fail <= 1'b0;
      erase_fail <= 1'b0;
    end else begin
      // supply high from start to after read command
      supply_high_level <= (next_state != S_IDLE) && (next_state != S_SETTLE);
      busy <= next_state != S_IDLE;
      done <= (state == S_SETTLE) && (next_state == S_IDLE);
      if (state == S_IDLE && (start_prog || start_erase)) begin
        prog_fail <= 1'b0;
        erase_fail <= 1'b0;
      end
      if (fail_p) prog_fail <= 1'b1;
      if (fail_e) erase_fail <= 1'b1;
    end
  end

  // we low only with ce low
  property p_we_ce;
    @(posedge clk) disable iff (!nrst) !fl_we_n |-> !fl_ce_n;
  endproperty
  a_we_ce: assert property (p_we_ce) else $error("we low without ce");

  property p_pulse_max;
    @(posedge clk) disable iff (!nrst) ppulse <= PROG_MAX_PULSES;
  endproperty
  a_pulse_max: assert property (p_pulse_max) else $error("too many pulses");

  property p_pvfy;
    @(posedge clk) disable iff (!nrst)
      (state == S_PP_VFY && $past(state) != S_PP_VFY) |->
      $past(state) == S_PP_PULSE;
  endproperty
  a_pvfy: assert property (p_pvfy) else $error("verify not after pulse");

  // erase verify after pulse or good byte
  property p_evfy;
    @(posedge clk) disable iff (!nrst)
      $rose(state == S_EV_CMD) |->
      ($past(state) == S_ER_PULSE || $past(state) == S_EV_RD);
  endproperty
  a_evfy: assert property (p_evfy) else $error("erase verify misplaced");

  property p_supply;
    @(posedge clk) disable iff (!nrst) !fl_we_n |-> supply_high_level;
  endproperty
  a_supply: assert property (p_supply) else $error("write at low supply");

  property p_pfail;
    @(posedge clk) disable iff (!nrst) fail_p |=> state == S_FIN;
  endproperty
  a_pfail: assert property (p_pfail) else $error("fail not to read");

  property p_efail;
    @(posedge clk) disable iff (!nrst) fail_e |-> epulse == ERASE_MAX_PULSES;
  endproperty
  a_efail: assert property (p_efail) else $error("early erase fail");

  property p_ready;
    @(posedge clk) disable iff (!nrst)
      (state == S_SUPPLY && !supply_ready) |=> state == S_SUPPLY;
  endproperty
  a_ready: assert property (p_ready) else $error("set-up before supply");

  c_prog: cover property (@(posedge clk) disable iff (!nrst) $rose(done));
  c_pfail: cover property (@(posedge clk) disable iff (!nrst) fail_p);
  c_erase: cover property (@(posedge clk) disable iff (!nrst)
    state == S_ER_PULSE);
endmodule : fps_sequencer

// [fps_flash_model.sv]
// Purpose: behavioural flash device facing the sequencer
// Assumes: commands taken on rising write enable with chip enable low
// Notes: viol counts host slips; a released bus keeps toggling
module fps_flash_model
  import fps_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic supply,
  input var int need,
  output logic [DATA_W-1:0] dq_in = 8'h00,
  output int pulses = 0,
  output int viol = 0,
  output int pulse_ns = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef enum int {RD, SUP, PUL, PVF, SUE, ERS, EVF, ABT} fps_fst_e;
  fps_fst_e st = RD;
  logic [7:0] mem [int];
  logic [7:0] dlat, pd;
  int alat = 0, pa = 0, ea = 0, pb = 0;
  int wlog [$];
  realtime t0;
  logic ce_lat = 1'b0; // chip enable seen while write enable is low
  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction : rd
  // array or margin read, else host data, else a changing pattern
  always @(ce_n, oe_n, addr, dq_oe, dq_out, st) begin
    if (!ce_n && !oe_n) dq_in = rd(st == PVF ? pa : st == EVF ? ea : addr);
    else if (dq_oe) dq_in = dq_out;
    else dq_in = ~dq_in;
  end
  // address on falling edge, data while write enable is low
  // host may raise ce and we in one step, so ce is judged while we is low
  always @(negedge we_n) begin
    #1 alat = addr;
    ce_lat = !ce_n;
  end
  always @(dq_out, we_n, ce_n) if (!we_n && !ce_n) dlat = dq_out;
  // write taken only with both enables low
  always @(posedge we_n) if (ce_lat) begin
    wlog.push_back((alat << 8) | dlat);
    if (!supply) viol++;
    case (st)
      // address and data, or first abort write
      SUP: begin
        pa = alat;
        pd = dlat;
        t0 = $realtime;
        st = (dlat == 8'hFF) ? ABT : PUL;
      end
      SUE: begin
        t0 = $realtime;
        st = (dlat == 8'hFF) ? ABT : (dlat == 8'h20) ? ERS : RD;
      end
      // C0h ends pulse; byte set once it takes
      PUL: begin
        pulse_ns = int'($realtime - t0);
        pulses++;
        pb++;
        if (need != 0 && pb >= need) mem[pa] = rd(pa) & pd;
        if (dlat != 8'hC0) viol++;
        st = PVF;
      end
      // A0h ends erasure of the whole array
      ERS: begin
        if (dlat != 8'hA0) viol++;
        mem.delete();
        ea = alat;
        st = EVF;
      end
      // verify codes only after a pulse
      default: case (dlat)
        8'h00: begin
          st = RD;
          pb = 0;
        end
        8'h40: st = SUP;
        8'h20: st = SUE;
        8'hA0: begin
          viol += (st != EVF);
          ea = alat;
        end
        8'hFF: begin
          viol += (st != ABT);
          st = RD;
        end
        default: viol++;
      endcase
    endcase
  end
endmodule : fps_flash_model

// [tb_flash_program_erase_sequencer.sv]
// Purpose: self-checking bench for the flash program/erase sequencer
// Assumes: flash model on the far side, supply ramp of nine cycles
// Notes: a full erase walks the whole array, so only its start is run
module tb_flash_program_erase_sequencer
  import fps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic start_prog = 1'b0;
  logic start_erase = 1'b0;
  logic supply_ready = 1'b0;
  logic [7:0] ramp = 8'h00;
  logic [ADDR_W-1:0] prog_addr = '0;
  logic [DATA_W-1:0] prog_data = '0;
  logic [DATA_W-1:0] fl_dq_in, fl_dq_out;
  logic [ADDR_W-1:0] fl_addr;
  logic fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, supply_high_level;
  logic busy, done, prog_fail, erase_fail;
  int need = 1;
  int err_count = 0;
  int cmp_count = 0;
  int n = 0;
  int exp_log [$];
  always #4 clk = ~clk;
  // supply reaches its high level nine cycles after the request
  always @(posedge clk) begin
    ramp <= {ramp[6:0], supply_high_level};
    supply_ready <= ramp[7];
  end
  fps_sequencer #(.ERASE_CYC(100)) u_dut (
    .clk, .nrst, .start_prog, .start_erase, .prog_addr, .prog_data,
    .supply_ready, .fl_dq_in, .fl_addr, .fl_dq_out, .fl_dq_oe, .fl_ce_n,
    .fl_we_n, .fl_oe_n, .supply_high_level, .busy, .done, .prog_fail,
    .erase_fail
  );
  fps_flash_model u_mdl (
    .addr(fl_addr), .dq_out(fl_dq_out), .dq_oe(fl_dq_oe), .ce_n(fl_ce_n),
    .we_n(fl_we_n), .oe_n(fl_oe_n), .supply(supply_high_level), .need,
    .dq_in(fl_dq_in), .pulses(), .viol(), .pulse_ns()
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // bus log against the expected writes; commands by data only
  task automatic chk_log();
    chk(u_mdl.wlog.size(), exp_log.size());
    foreach (exp_log[i]) begin
      if (i < u_mdl.wlog.size())
        chk(exp_log[i][30] ? u_mdl.wlog[i] & 32'hFF : u_mdl.wlog[i],
            exp_log[i] & 32'h01FF_FFFF);
    end
  endtask : chk_log
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic tick(input int lim);
    @(posedge clk);
    n++;
    if (n >= lim) begin
      err_count++;
      $display("Error at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask : tick
  // one program flow; k pulses needed, 0 for a byte that never takes
  task automatic run_prog(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, input int k);
    int p0, np;
    logic fail;
    p0 = u_mdl.pulses;
    fail = (k == 0 || k > PROG_MAX_PULSES);
    np = fail ? PROG_MAX_PULSES : k;
    exp_log.delete();
    u_mdl.wlog.delete();
    repeat (np) begin
      exp_log.push_back(32'h4000_0040);
      exp_log.push_back({a, d});
      exp_log.push_back(32'h4000_00C0);
    end
    exp_log.push_back(32'h4000_0000);
    need <= k;
    prog_addr <= a;
    prog_data <= d;
    start_prog <= 1'b1;
    @(posedge clk);
    start_prog <= 1'b0;
    n = 0;
    while (done !== 1'b1) tick(60000);
    chk(u_mdl.pulses - p0, np);
    chk(prog_fail, fail);
    chk(erase_fail, 0);
    chk(u_mdl.rd(a), fail ? 8'hFF : d);
    chk(u_mdl.pulse_ns >= PROG_PULSE_US * 1000, 1);
    chk(u_mdl.viol, 0);
    chk({u_mdl.st, supply_high_level}, 0);
    chk_log();
  endtask : run_prog
  initial begin
    void'($urandom(32'h7262));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(u_mdl.st, 0);
    chk({fl_ce_n, fl_we_n, busy}, 3'b110);
    $display("test reset done");
    for (int t = 0; t < 4; t++) begin
      run_prog(ADDR_W'($urandom), DATA_W'($urandom) & 8'hFE, 1 + $urandom % 3);
      $display("test program %0d done", t);
    end
    run_prog(17'h1_2345, 8'h3C, 0);
    $display("test stuck byte done");
    // written array: blank check fails, preprogram starts at zero
    u_mdl.mem[0] = 8'h5A;
    need <= 1;
    start_erase <= 1'b1;
    @(posedge clk);
    start_erase <= 1'b0;
    n = 0;
    while (u_mdl.st != 2) tick(8000);
    chk({u_mdl.pa, u_mdl.pd}, 0);
    chk({supply_high_level, busy}, 2'b11);
    chk(u_mdl.viol, 0);
    nrst <= 1'b0;
    @(posedge clk);
    chk({fl_ce_n, fl_we_n, fl_oe_n, supply_high_level}, 4'hE);
    chk({fl_dq_oe, busy}, 2'b00);
    nrst <= 1'b1;
    $display("test erase start done");
    report_and_stop();
  end
endmodule : tb_flash_program_erase_sequencer
